/* File: sfp_pkg.sv */
`default_nettype none
package sfp_pkg;

  // ----------------------------------------------------------------
  // Clock rate and instruction codes
  // ----------------------------------------------------------------
  localparam int          CLK_MHZ             = 50;
  localparam logic [7:0]  OP_PAGE_WRITE       = 8'h02;
  localparam logic [7:0]  OP_PAGE_CLEAR       = 8'h81;
  localparam logic [7:0]  OP_SECTOR_CLEAR     = 8'hD8;
  localparam logic [7:0]  OP_ARRAY_CLEAR      = 8'hC7;
  localparam logic [7:0]  OP_SOFT_PROTECT     = 8'hB9;
  localparam logic [7:0]  OP_DEEP_SLEEP       = 8'hBA;
  localparam logic [7:0]  OP_RELEASE          = 8'hAB;
  localparam logic [7:0]  OP_WRITE_UNLOCK     = 8'h06;

  // ----------------------------------------------------------------
  // Status byte layout and reset values
  // ----------------------------------------------------------------
  localparam int          ST_BUSY_BIT         = 0;
  localparam int          ST_WEN_BIT          = 1;
  localparam int          ST_LVL_LO_BIT       = 2;
  localparam int          ST_LVL_HI_BIT       = 3;
  localparam logic        WEN_RESET           = 1'b0;
  localparam logic        PROTECT_RESET       = 1'b0;

  // ----------------------------------------------------------------
  // Array geometry and block-protect boundaries
  // ----------------------------------------------------------------
  localparam logic [15:0] PROT_START_QUARTER  = 16'hC000;
  localparam logic [15:0] PROT_START_HALF     = 16'h8000;
  localparam logic [15:0] PROT_START_ALL      = 16'h0000;
  localparam logic [15:0] SECTOR_SPAN         = 16'h7FFF;
  localparam logic [15:0] ARRAY_LAST          = 16'hFFFF;
  localparam logic [7:0]  PAGE_LAST_COL       = 8'hFF;
  localparam logic [7:0]  ERASED_BYTE         = 8'hFF;

  // ----------------------------------------------------------------
  // Frame lengths in whole bytes, and the last bit index within a byte
  // ----------------------------------------------------------------
  localparam logic [2:0]  BYTES_OPCODE_ONLY   = 3'h1;
  localparam logic [2:0]  BYTES_WITH_ADDR     = 3'h4;
  localparam logic [2:0]  BYTES_PROG_MIN      = 3'h5;
  localparam logic [2:0]  BYTES_SATURATE      = 3'h7;
  localparam logic [2:0]  BIT_LAST            = 3'h7;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          PROTECT_ENTRY_DELAY_US = 10;
  localparam int          PROTECT_ENTRY_CYCLES   = PROTECT_ENTRY_DELAY_US * CLK_MHZ;

  typedef enum logic [1:0]
  {
    FS_IDLE  = 2'b00,
    FS_WORK  = 2'b01,
    FS_WAIT  = 2'b10,
    FS_ENTRY = 2'b11
  } sfp_state_t;

  // Snapshot of one select-low frame, built on the serial clock.
  typedef struct packed
  {
    logic [7:0] opcode;
    logic [7:0] page;
    logic [2:0] bytes;
    logic [2:0] bits;
  } sfp_frame_t;

endpackage
`default_nettype wire

/* File: sfp_flash_seq.sv */
`timescale 1ns/100ps
`default_nettype none
module sfp_flash_seq #(
  parameter int PAGE_WRITE_TIME_US   = 2000,
  parameter int PAGE_CLEAR_TIME_US   = 2000,
  parameter int SECTOR_CLEAR_TIME_US = 2000,
  parameter int ARRAY_CLEAR_TIME_US  = 2000
) (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic        sck_i,
  input  wire logic        select_n_i,
  input  wire logic        data_in_i,
  input  wire logic [1:0]  protect_level_i,
  input  wire logic [15:0] rd_addr_i,
  output var  logic [7:0]  rd_data_o,
  output var  logic [7:0]  status_o,
  output var  logic        protect_mode_o
);
  import sfp_pkg::*;

  localparam logic [31:0] PAGE_WRITE_CYCLES   = 32'(PAGE_WRITE_TIME_US * CLK_MHZ);
  localparam logic [31:0] PAGE_CLEAR_CYCLES   = 32'(PAGE_CLEAR_TIME_US * CLK_MHZ);
  localparam logic [31:0] SECTOR_CLEAR_CYCLES = 32'(SECTOR_CLEAR_TIME_US * CLK_MHZ);
  localparam logic [31:0] ARRAY_CLEAR_CYCLES  = 32'(ARRAY_CLEAR_TIME_US * CLK_MHZ);
  localparam logic [31:0] ENTRY_CYCLES        = 32'(PROTECT_ENTRY_CYCLES);

  // Start of the protected top region for a level; level zero protects nothing.
  function automatic logic region_locked(input logic [1:0] lvl, input logic [15:0] last_addr);
    logic [15:0] start;
    start = PROT_START_ALL;
    case (lvl)
      2'h1:    start = PROT_START_QUARTER;
      2'h2:    start = PROT_START_HALF;
      default: start = PROT_START_ALL;
    endcase
    return (lvl != 2'h0) && (last_addr >= start);
  endfunction

  // ----------------------------------------------------------------
  // Link side, clocked by the serial clock
  // ----------------------------------------------------------------
  logic         fresh;
  logic         frame_tog;
  sfp_frame_t   frame;
  logic [7:0]   shift_reg;
  logic [7:0]   col_reg;
  logic [255:0] page_mask;
  logic [7:0]   page_buf [0:255];
  logic         lk_busy1;
  logic         lk_busy2;
  logic [7:0]   shift_in;
  logic         byte_done;
  logic         buf_open;
  logic         busy;

  // The first sample of each frame restarts the byte assembly.
  assign shift_in  = fresh ? {7'h00, data_in_i} : {shift_reg[6:0], data_in_i};
  assign byte_done = !fresh && (frame.bits == BIT_LAST);
  assign buf_open  = (frame.opcode == OP_PAGE_WRITE) && !lk_busy2;

  // Fresh marks that select has been high since the last serial edge.
  always_ff @(posedge sck_i or posedge select_n_i or posedge rst_i)
  begin
    if (select_n_i || rst_i)
      fresh <= 1'b1;
    else
      fresh <= 1'b0;
  end

  // Busy level brought over to the link; the clock only runs inside frames,
  // but two edges of every frame pass before the data bytes arrive.
  always_ff @(posedge sck_i)
  begin
    lk_busy1 <= busy;
    lk_busy2 <= lk_busy1;
  end

  // Bit and byte assembly of the frame.
  always_ff @(posedge sck_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      frame     <= '0;
      frame_tog <= 1'b0;
      shift_reg <= 8'h00;
    end
    else
    begin
      shift_reg <= shift_in;
      if (fresh)
      begin
        frame.bits  <= 3'h1;
        frame.bytes <= 3'h0;
        frame_tog   <= ~frame_tog;
      end
      else
      begin
        frame.bits <= frame.bits + 3'h1;
        if (byte_done)
        begin
          if (frame.bytes == 3'h0)
            frame.opcode <= shift_in;
          if (frame.bytes == 3'h2)
            frame.page <= shift_in;
          if (frame.bytes != BYTES_SATURATE)
            frame.bytes <= frame.bytes + 3'h1;
        end
      end
    end
  end

  // Page buffer: the column steps through the low address byte only, so a long
  // burst wraps and overwrites what it loaded earlier in the same frame.
  always_ff @(posedge sck_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      col_reg   <= 8'h00;
      page_mask <= '0;
    end
    else if (byte_done && (frame.bytes == 3'h3))
    begin
      col_reg <= shift_in;
      if (buf_open)
        page_mask <= '0;
    end
    else if (byte_done && (frame.bytes >= 3'h4))
    begin
      col_reg <= col_reg + 8'h01;
      if (buf_open)
        page_mask[col_reg] <= 1'b1;
    end
  end

  // Buffer storage; held still while a program cycle reads it.
  always_ff @(posedge sck_i)
  begin
    if (byte_done && (frame.bytes >= 3'h4) && buf_open)
      page_buf[col_reg] <= shift_in;
  end

  chk_col_wrap: assert property (@(posedge sck_i) disable iff (rst_i || select_n_i)
    (byte_done && frame.bytes >= 3'h4) |=> (col_reg == $past(col_reg) + 8'h01))
    else $error("column did not step by one within the page");

  // ----------------------------------------------------------------
  // Crossing into the system clock
  // ----------------------------------------------------------------
  logic       sel_s1;
  logic       sel_s2;
  logic       sel_s3;
  logic       tog_s1;
  logic       tog_s2;
  logic       tog_seen;
  logic [1:0] lvl_s1;
  logic [1:0] lvl_s2;
  logic       frame_end;
  logic       new_frame;

  // Two-stage synchronisers. The frame snapshot itself is read only after
  // select has risen, when the serial clock stands still and it is stable.
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      sel_s1 <= 1'b1;
      sel_s2 <= 1'b1;
      sel_s3 <= 1'b1;
      tog_s1 <= 1'b0;
      tog_s2 <= 1'b0;
      lvl_s1 <= 2'h0;
      lvl_s2 <= 2'h0;
    end
    else
    begin
      sel_s1 <= select_n_i;
      sel_s2 <= sel_s1;
      sel_s3 <= sel_s2;
      tog_s1 <= frame_tog;
      tog_s2 <= tog_s1;
      lvl_s1 <= protect_level_i;
      lvl_s2 <= lvl_s1;
    end
  end

  assign frame_end = sel_s2 && !sel_s3;
  assign new_frame = frame_end && (tog_s2 != tog_seen);

  // A select pulse with no serial clock must not replay the last frame.
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      tog_seen <= 1'b0;
    else if (frame_end)
      tog_seen <= tog_s2;
  end

  // ----------------------------------------------------------------
  // Instruction decode at select rising
  // ----------------------------------------------------------------
  sfp_state_t  state_reg;
  logic        wen_reg;
  logic        prot_reg;
  logic [31:0] timer_reg;
  logic [15:0] sw_addr_reg;
  logic [15:0] sw_end_reg;
  logic        sw_prog_reg;
  logic        one_byte;
  logic        addr_only;
  logic        prog_len;
  logic [15:0] page_base;
  logic        go_prog;
  logic        go_page;
  logic        go_sector;
  logic        go_array;
  logic        go_protect;
  logic        go_release;
  logic        go_unlock;
  logic        accept;

  assign one_byte  = (frame.bits == 3'h0) && (frame.bytes == BYTES_OPCODE_ONLY);
  assign addr_only = (frame.bits == 3'h0) && (frame.bytes == BYTES_WITH_ADDR);
  assign prog_len  = (frame.bits == 3'h0) && (frame.bytes >= BYTES_PROG_MIN);
  assign page_base = {frame.page, 8'h00};
  assign busy      = (state_reg == FS_WORK) || (state_reg == FS_WAIT);
  // Nothing but a finished frame in idle standby is looked at.
  assign accept    = new_frame && (state_reg == FS_IDLE);

  // Misaligned select rises fail the length terms and start nothing.
  assign go_prog    = accept && !prot_reg && wen_reg && prog_len
                      && (frame.opcode == OP_PAGE_WRITE)
                      && !region_locked(lvl_s2, page_base | {8'h00, PAGE_LAST_COL});
  assign go_page    = accept && !prot_reg && wen_reg && addr_only
                      && (frame.opcode == OP_PAGE_CLEAR)
                      && !region_locked(lvl_s2, page_base | {8'h00, PAGE_LAST_COL});
  assign go_sector  = accept && !prot_reg && wen_reg && addr_only
                      && (frame.opcode == OP_SECTOR_CLEAR)
                      && !region_locked(lvl_s2, (page_base & ~SECTOR_SPAN) | SECTOR_SPAN);
  assign go_array   = accept && !prot_reg && wen_reg && one_byte
                      && (frame.opcode == OP_ARRAY_CLEAR) && (lvl_s2 == 2'h0);
  assign go_protect = accept && !prot_reg && one_byte
                      && ((frame.opcode == OP_SOFT_PROTECT) || (frame.opcode == OP_DEEP_SLEEP));
  assign go_unlock  = accept && !prot_reg && one_byte && (frame.opcode == OP_WRITE_UNLOCK);
  assign go_release = accept && prot_reg && (frame.bits == 3'h0)
                      && (frame.bytes != 3'h0) && (frame.opcode == OP_RELEASE);

  // ----------------------------------------------------------------
  // Self-timed cycle sequencer
  // ----------------------------------------------------------------
  // The timer must be at least as long as the sweep; the cycle ends when both
  // the sweep is through and the timer has run out.
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      state_reg   <= FS_IDLE;
      timer_reg   <= 32'h0000_0000;
      sw_addr_reg <= 16'h0000;
      sw_end_reg  <= 16'h0000;
      sw_prog_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        FS_IDLE:
        begin
          sw_prog_reg <= go_prog;
          if (go_prog || go_page)
          begin
            state_reg   <= FS_WORK;
            sw_addr_reg <= page_base;
            sw_end_reg  <= page_base | {8'h00, PAGE_LAST_COL};
            timer_reg   <= go_prog ? PAGE_WRITE_CYCLES : PAGE_CLEAR_CYCLES;
          end
          else if (go_sector)
          begin
            state_reg   <= FS_WORK;
            sw_addr_reg <= page_base & ~SECTOR_SPAN;
            sw_end_reg  <= (page_base & ~SECTOR_SPAN) | SECTOR_SPAN;
            timer_reg   <= SECTOR_CLEAR_CYCLES;
          end
          else if (go_array)
          begin
            state_reg   <= FS_WORK;
            sw_addr_reg <= 16'h0000;
            sw_end_reg  <= ARRAY_LAST;
            timer_reg   <= ARRAY_CLEAR_CYCLES;
          end
          else if (go_protect)
          begin
            state_reg <= FS_ENTRY;
            timer_reg <= ENTRY_CYCLES;
          end
        end
        FS_WORK:
        begin
          if (timer_reg != 32'h0000_0000)
            timer_reg <= timer_reg - 32'h0000_0001;
          if (sw_addr_reg == sw_end_reg)
            state_reg <= FS_WAIT;
          else
            sw_addr_reg <= sw_addr_reg + 16'h0001;
        end
        FS_WAIT, FS_ENTRY:
        begin
          if (timer_reg == 32'h0000_0000)
            state_reg <= FS_IDLE;
          else
            timer_reg <= timer_reg - 32'h0000_0001;
        end
        default:
          state_reg <= FS_IDLE;
      endcase
    end
  end

  // Write enable: set by unlock, dropped as soon as any program or erase cycle starts; protect entry keeps it.
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      wen_reg <= WEN_RESET;
    else if (go_prog || go_page || go_sector || go_array)
      wen_reg <= 1'b0;
    else if (go_unlock)
      wen_reg <= 1'b1;
  end

  // Protect mode: entered when the entry delay runs out, left on release.
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      prot_reg <= PROTECT_RESET;
    else if ((state_reg == FS_ENTRY) && (timer_reg == 32'h0000_0000))
      prot_reg <= 1'b1;
    else if (go_release)
      prot_reg <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Array storage
  // ----------------------------------------------------------------
  logic [7:0] mem [0:65535];
  logic [7:0] mem_cur;
  logic [7:0] buf_cur;

  assign mem_cur = mem[sw_addr_reg];
  assign buf_cur = page_buf[sw_addr_reg[7:0]];

  // One byte per clock; a program ANDs so a one is never written back.
  always_ff @(posedge clock_i)
  begin
    if (state_reg == FS_WORK)
    begin
      if (!sw_prog_reg)
        mem[sw_addr_reg] <= ERASED_BYTE;
      else if (page_mask[sw_addr_reg[7:0]])
        mem[sw_addr_reg] <= mem_cur & buf_cur;
    end
  end

  // Read port for inspecting the array.
  always_ff @(posedge clock_i)
  begin
    rd_data_o <= mem[rd_addr_i];
  end

  // Status byte and protect flag come from registers.
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      status_o       <= 8'h00;
      protect_mode_o <= 1'b0;
    end
    else
    begin
      status_o                <= 8'h00;
      status_o[ST_BUSY_BIT]   <= busy;
      status_o[ST_WEN_BIT]    <= wen_reg;
      status_o[ST_LVL_LO_BIT] <= lvl_s2[0];
      status_o[ST_LVL_HI_BIT] <= lvl_s2[1];
      protect_mode_o          <= prot_reg;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  sequence s_cycle_start;
    (state_reg == FS_IDLE) ##1 (state_reg == FS_WORK);
  endsequence

  chk_start_drops_wen: assert property (s_cycle_start |-> !wen_reg)
    else $error("write enable still set after cycle start");
  chk_end_disabled: assert property ($fell(busy) |-> !wen_reg && (state_reg == FS_IDLE))
    else $error("cycle ended write-enabled");
  chk_busy_ignores: assert property ((busy && new_frame) |=> $stable(prot_reg) && $stable(wen_reg))
    else $error("instruction acted on during busy cycle");
  chk_nowen_noop: assert property ((accept && !wen_reg) |=> (state_reg != FS_WORK))
    else $error("write started without write enable");
  chk_bulk_level: assert property ((s_cycle_start ##0 ((sw_end_reg == ARRAY_LAST) && (sw_addr_reg == 16'h0000)))
    |-> $past(lvl_s2, 1) == 2'h0)
    else $error("bulk erase ran under block protect");
  chk_prog_and_only: assert property ((state_reg == FS_WORK && sw_prog_reg && page_mask[sw_addr_reg[7:0]])
    |=> mem[$past(sw_addr_reg)] == ($past(mem_cur) & $past(buf_cur)))
    else $error("program set a bit to one");
  chk_entry_delay: assert property ($rose(prot_reg) |-> $past(state_reg) == FS_ENTRY
    && $past(timer_reg) == 32'h0000_0000)
    else $error("protect mode entered without its delay");
  chk_prot_ignores: assert property ((prot_reg && accept && frame.opcode != OP_RELEASE)
    |=> prot_reg && state_reg == FS_IDLE)
    else $error("protect mode acted on an instruction");
  chk_status_busy: assert property (busy |-> ##1 status_o[ST_BUSY_BIT])
    else $error("busy flag not shown in status");

endmodule
`default_nettype wire

/* File: sfp_master_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// Serial master model
// ------------------------------------------------------------
module sfp_master_model (
  output var logic sck_o,
  output var logic select_n_o,
  output var logic data_o
);
  // Idle bus: select high and the clock standing still.
  initial
  begin
    sck_o      = 1'b0;
    select_n_o = 1'b1;
    data_o     = 1'b0;
  end

  // Shifts the leading bits of a frame out MSB first on a 12 ns clock.
  // A bit count off a byte boundary lets a test break the framing on purpose.
  task automatic send(input logic [63:0] frame, input int nbits);
    select_n_o = 1'b0;
    for (int i = 0; i < nbits; i++)
    begin
      data_o = frame[63 - i];
      #6;
      sck_o = 1'b1;
      #6;
      sck_o = 1'b0;
    end
    #2;
    select_n_o = 1'b1;
    data_o     = ~data_o;      // A released line must not keep the last bit.
    #120;                      // Select stays high long enough between frames.
  endtask
endmodule
`default_nettype wire

/* File: sfp_flash_seq_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module sfp_flash_seq_tb_top;
  import sfp_pkg::*;
  logic        clock_i = 1'b0;
  logic        rst_i;
  logic [1:0]  protect_level_i = 2'h0;
  logic [15:0] rd_addr_i = 16'h0000;
  logic        sck;
  logic        select_n;
  logic        data_in;
  logic [7:0]  rd_data_o;
  logic [7:0]  status_o;
  logic        protect_mode_o;
  int          failures = 0;
  int          check_count = 0;

  // Clock at 50 MHz.
  always #10 clock_i = ~clock_i;

  sfp_master_model i_master (.sck_o(sck), .select_n_o(select_n), .data_o(data_in));

  // Short timers keep each cycle just above its sweep length.
  sfp_flash_seq #(.PAGE_WRITE_TIME_US(6), .PAGE_CLEAR_TIME_US(6), .SECTOR_CLEAR_TIME_US(700),
    .ARRAY_CLEAR_TIME_US(1311)) i_dut (.clock_i(clock_i), .rst_i(rst_i), .sck_i(sck),
    .select_n_i(select_n), .data_in_i(data_in), .protect_level_i(protect_level_i),
    .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o), .status_o(status_o),
    .protect_mode_o(protect_mode_o));

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Waits, bounded, for {protect_mode_o, status_o} under a mask to match.
  task automatic wait_for(input logic [8:0] mask, input logic [8:0] exp, input int lim);
    int n;
    n = 0;
    while ((({protect_mode_o, status_o} & mask) !== exp) && n < lim)
    begin
      @(posedge clock_i);
      n++;
    end
    check({protect_mode_o, status_o} & mask, exp);
    // Only a bound that ran out without a match ends the run early.
    if ((n >= lim) && (({protect_mode_o, status_o} & mask) !== exp))
      report_and_stop();
  endtask

  // The read port answers one clock after the address; sample two clocks later.
  task automatic rd(input logic [15:0] addr, input logic [7:0] exp);
    @(posedge clock_i);
    rd_addr_i <= addr;
    repeat (3) @(posedge clock_i);
    check({1'b0, rd_data_o}, {1'b0, exp});
  endtask

  task automatic cmd(input logic [63:0] frame, input int nbits);
    i_master.send(frame, nbits);
    repeat (20) @(posedge clock_i);
  endtask

  // Main sequence: each test ends with one line.
  initial
  begin
    // A real rising edge on reset is needed to clear the serial-side flops.
    rst_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    check({protect_mode_o, status_o}, 9'h000);
    cmd({OP_WRITE_UNLOCK, 56'h0}, 8);
    wait_for(9'h1FF, 9'h002, 20);
    i_master.send({OP_PAGE_CLEAR, 24'h001000, 32'h0}, 32);
    wait_for(9'h1FF, 9'h001, 20);
    wait_for(9'h1FF, 9'h000, 400);
    rd(16'h1000, 8'hFF);
    rd(16'h10FF, 8'hFF);
    cmd({OP_PAGE_WRITE, 24'h0010FE, 24'hA53C0F, 8'h0}, 56);
    check({protect_mode_o, status_o}, 9'h000);
    rd(16'h10FE, 8'hFF);
    $display("test erase and refused program done");
    cmd({OP_WRITE_UNLOCK, 56'h0}, 8);
    i_master.send({OP_PAGE_WRITE, 24'h0010FE, 24'hA53C0F, 8'h0}, 56);
    wait_for(9'h1FF, 9'h001, 20);
    i_master.send({OP_WRITE_UNLOCK, 56'h0}, 8);
    i_master.send({OP_SOFT_PROTECT, 56'h0}, 8);
    wait_for(9'h1FF, 9'h000, 400);
    repeat (600) @(posedge clock_i);
    check({protect_mode_o, status_o}, 9'h000);
    rd(16'h10FE, 8'hA5);
    rd(16'h10FF, 8'h3C);
    rd(16'h1000, 8'h0F);
    cmd({OP_WRITE_UNLOCK, 56'h0}, 8);
    i_master.send({OP_PAGE_WRITE, 24'h0010FE, 8'hF0, 24'h0}, 40);
    wait_for(9'h1FF, 9'h001, 20);
    wait_for(9'h1FF, 9'h000, 400);
    rd(16'h10FE, 8'hA0);
    $display("test program wrap and busy refusal done");
    cmd({OP_WRITE_UNLOCK, 56'h0}, 8);
    cmd({OP_PAGE_CLEAR, 24'h001000, 32'h0}, 31);
    check({protect_mode_o, status_o}, 9'h002);
    protect_level_i <= 2'h3;
    cmd({OP_PAGE_CLEAR, 24'h001000, 32'h0}, 32);
    check({protect_mode_o, status_o}, 9'h00E);
    protect_level_i <= 2'h1;
    cmd({OP_ARRAY_CLEAR, 56'h0}, 8);
    check({protect_mode_o, status_o}, 9'h006);
    cmd({OP_SECTOR_CLEAR, 24'h008000, 32'h0}, 32);
    check({protect_mode_o, status_o}, 9'h006);
    rd(16'h10FE, 8'hA0);
    protect_level_i <= 2'h0;
    i_master.send({OP_ARRAY_CLEAR, 56'h0}, 8);
    wait_for(9'h1FF, 9'h001, 20);
    wait_for(9'h1FF, 9'h000, 66000);
    rd(16'hFFFF, 8'hFF);
    rd(16'h10FE, 8'hFF);
    cmd({OP_WRITE_UNLOCK, 56'h0}, 8);
    $display("test framing and protect levels done");
    // Both sleep opcodes must enter and leave protect mode alike.
    for (int k = 0; k < 2; k++)
    begin
      cmd({(k == 0) ? OP_SOFT_PROTECT : OP_DEEP_SLEEP, 56'h0}, 8);
      wait_for(9'h100, 9'h100, 600);
      cmd({OP_PAGE_CLEAR, 24'h001000, 32'h0}, 32);
      wait_for(9'h101, 9'h100, 2);
      cmd({OP_RELEASE, 56'h0}, 8);
      wait_for(9'h101, 9'h000, 20);
    end
    $display("test protect mode done");
    report_and_stop();
  end
endmodule
`default_nettype wire
